//--- hdl/slc_pkg.sv
// slc_pkg: register map, field layouts, reset values and carriers of the
// strap latch and pin output control block
// assumes one 100 MHz clock and an AXI4-Lite master with 32-bit data
// Function
// - sample and hold every strap input when the chip reset is released
// - jack strap low gives normal defaults, high gives jack-specific defaults
// - five address strap bits form the management address, 0 to 1fh
// - led strap zero gives active-high polarity bit one, strap one gives zero
// - broadcast strap low answers address zero too; enable bit is its inverse
// - reference clock strap low disables the clock pin output, high enables it
// - led style strap low picks tri-color, high picks individual leds
// - latch five function strap bits and use the code as operating function
// - code 01000 powers down with pll on, 01001 pll off, 00111 device off
// - each led follows polarity and buffer bits; open type drains or sources
// - interrupt defaults open-drain active low; buffer and invert bits steer it
// - an open-drain interrupt output is always active low
// - management data pin is push-pull or open-drain by its own bit
// - wake output asserts on wake events with own polarity and buffer bits
// - start-of-frame outputs pulse per frame and are always active high
// - each timestamp-counter event output asserts with its own polarity bit
// - general-purpose input captures a timestamp and clears event interrupts
// - clock pin drives local or receive clock, or takes a timestamp clock in
package slc_pkg;
  localparam int         AW         = 5;
  localparam logic [4:0] REG_STRAP  = 5'h00;
  localparam logic [4:0] REG_OCTL   = 5'h04;
  localparam logic [4:0] REG_STAT   = 5'h08;
  localparam logic [4:0] REG_GBUF   = 5'h0c;
  localparam logic [4:0] REG_TSCAP  = 5'h10;
  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;
  localparam logic [4:0] FUNC_PD    = 5'h07;
  localparam logic [4:0] FUNC_SWPD  = 5'h08;
  localparam logic [4:0] FUNC_SWPDN = 5'h09;
  localparam logic [1:0] SYNC_FILL  = 2'h3;
  localparam int         NLED       = 5;
  localparam int         NPIN       = 11;
  localparam int         PIN_INT    = 5;
  localparam int         PIN_WAKE   = 6;
  localparam int         PIN_SOFRX  = 7;
  localparam int         PIN_SOFTX  = 8;
  localparam int         PIN_LTCA   = 9;
  localparam int         PIN_LTCB   = 10;
  localparam int         NLEDSTRAP  = 3;

  typedef struct packed {
    logic [4:0] func;
    logic [2:0] led_pol;
    logic       led_style;
    logic       ref_clk_out;
    logic       iface_sel;
    logic       jack;
    logic       bcast;
    logic [4:0] addr;
  } slc_strap_s;

  typedef struct packed {
    logic       mdio_od;
    logic       ltc_pol_b;
    logic       ltc_pol_a;
    logic       wake_pol;
    logic       int_pol_inv;
    logic       int_od;
    logic [4:0] led_od;
    logic [4:0] led_pol;
  } slc_octl_s;

  typedef struct packed {
    logic refclk_in;
    logic refclk_rx;
    logic ltc_b_od;
    logic ltc_a_od;
    logic sof_tx_od;
    logic sof_rx_od;
    logic wake_od;
  } slc_gbuf_s;

  typedef struct packed {
    logic       done;
    logic       swpd_pll_on;
    logic       swpd_pll_off;
    logic       dev_pd;
    logic       rgmii;
    logic       refclk_en;
    logic       tri_color;
    logic       jack_dflt;
    logic       bcast_en;
    logic [4:0] addr;
    logic [4:0] func;
  } slc_stat_s;

  localparam int OCTL_W = $bits(slc_octl_s);
  localparam int GBUF_W = $bits(slc_gbuf_s);

  localparam slc_octl_s OCTL_RST = '{mdio_od: 1'h0, ltc_pol_b: 1'h1, ltc_pol_a: 1'h1,
                                     wake_pol: 1'h0, int_pol_inv: 1'h0, int_od: 1'h1,
                                     led_od: 5'h00, led_pol: 5'h00};
  localparam slc_gbuf_s GBUF_RST = '0;
endpackage : slc_pkg

//--- hdl/slc_strap_latch_pin_ctrl.sv
// slc_strap_latch_pin_ctrl: strap capture at reset release, address match,
// function decode and polarity/buffer control of the shared output pins
// assumes straps and the capture input come from pins; core events share clk
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module slc_strap_latch_pin_ctrl (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic [slc_pkg::AW-1:0]     s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [slc_pkg::AW-1:0]     s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire slc_pkg::slc_strap_s        strap_pins,
  output slc_pkg::slc_stat_s              cfg,
  input  wire logic [4:0]                 req_addr,
  output logic                            addr_hit,
  input  wire logic [slc_pkg::NLED-1:0]   led_active,
  input  wire logic                       int_active,
  input  wire logic                       wol_event,
  input  wire logic                       sof_rx_evt,
  input  wire logic                       sof_tx_evt,
  input  wire logic                       ltc_evt_a,
  input  wire logic                       ltc_evt_b,
  output logic [slc_pkg::NLED-1:0]        led_o,
  output logic [slc_pkg::NLED-1:0]        led_oe,
  output logic                            int_o,
  output logic                            int_oe,
  output logic                            wake_event_out_o,
  output logic                            wake_event_out_oe,
  output logic                            sof_rx_o,
  output logic                            sof_rx_oe,
  output logic                            sof_tx_o,
  output logic                            sof_tx_oe,
  output logic                            ltc_a_o,
  output logic                            ltc_a_oe,
  output logic                            ltc_b_o,
  output logic                            ltc_b_oe,
  input  wire logic                       mdio_out_data,
  input  wire logic                       mdio_out_en,
  output logic                            mdio_o,
  output logic                            mdio_oe,
  input  wire logic                       local_ref_clk,
  input  wire logic                       rx_ref_clk,
  input  wire logic                       ref_clk_pin_i,
  output logic                            ref_clk_pin_o,
  output logic                            ref_clk_pin_oe,
  output logic                            ts_ref_clk,
  input  wire logic                       gpio_ts_in,
  input  wire logic [31:0]                ts_count,
  output logic                            ltc_irq_clr
);

  // ---------------------------------------------------------------------
  // strap synchroniser and one-shot latch
  // ---------------------------------------------------------------------
  slc_pkg::slc_strap_s st1;
  slc_pkg::slc_strap_s st2;
  slc_pkg::slc_strap_s st3;
  slc_pkg::slc_strap_s strap;
  logic [1:0]          fill;
  logic                done;
  logic                latch_now;

  assign latch_now = !done && (fill == slc_pkg::SYNC_FILL) && (st2 == st3);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st1  <= '0;
      st2  <= '0;
      st3  <= '0;
      fill <= '0;
    end else begin
      st1 <= strap_pins;
      st2 <= st1;
      st3 <= st2;
      if (fill != slc_pkg::SYNC_FILL) begin
        fill <= fill + 2'h1;
      end
    end
  end

  // captured once after release, then frozen until the next reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap <= '0;
      done  <= 1'h0;
    end else if (latch_now) begin
      strap <= st3;
      done  <= 1'h1;
    end
  end

  // ---------------------------------------------------------------------
  // decoded configuration
  // ---------------------------------------------------------------------
  logic bcast_en;

  assign bcast_en            = done && !strap.bcast;
  assign cfg.done            = done;
  assign cfg.swpd_pll_on     = done && (strap.func == slc_pkg::FUNC_SWPD);
  assign cfg.swpd_pll_off    = done && (strap.func == slc_pkg::FUNC_SWPDN);
  assign cfg.dev_pd          = done && (strap.func == slc_pkg::FUNC_PD);
  assign cfg.func            = strap.func;
  assign cfg.rgmii           = strap.iface_sel;
  assign cfg.refclk_en       = strap.ref_clk_out;
  assign cfg.tri_color       = done && !strap.led_style;
  assign cfg.jack_dflt       = strap.jack;
  assign cfg.bcast_en        = bcast_en;
  assign cfg.addr            = strap.addr;
  assign addr_hit = done && ((req_addr == strap.addr) || (bcast_en && (req_addr == '0)));

  // ---------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------
  slc_pkg::slc_octl_s   octl;
  slc_pkg::slc_gbuf_s   gbuf;
  logic [31:0]          ts_cap;
  logic                 aw_held;
  logic                 w_held;
  logic [slc_pkg::AW-1:0] aw_addr_q;
  logic [31:0]          w_data_q;
  logic [3:0]           w_strb_q;
  logic                 wr_go;
  logic                 wr_octl;
  logic                 wr_gbuf;
  logic                 wr_ro;
  logic [31:0]          wmask;
  logic [31:0]          octl_wr;
  logic [31:0]          gbuf_wr;
  logic [31:0]          rd_word;
  logic                 rd_hit;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go   = aw_held && w_held && !s_axi_bvalid;
  assign wr_octl = wr_go && (aw_addr_q == slc_pkg::REG_OCTL);
  assign wr_gbuf = wr_go && (aw_addr_q == slc_pkg::REG_GBUF);
  assign wr_ro   = (aw_addr_q == slc_pkg::REG_STRAP) || (aw_addr_q == slc_pkg::REG_STAT)
                || (aw_addr_q == slc_pkg::REG_TSCAP);
  assign wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign octl_wr = (32'(octl) & ~wmask) | (w_data_q & wmask);
  assign gbuf_wr = (32'(gbuf) & ~wmask) | (w_data_q & wmask);

  assign rd_hit  = (s_axi_araddr == slc_pkg::REG_STRAP) || (s_axi_araddr == slc_pkg::REG_OCTL)
                || (s_axi_araddr == slc_pkg::REG_STAT) || (s_axi_araddr == slc_pkg::REG_GBUF)
                || (s_axi_araddr == slc_pkg::REG_TSCAP);
  assign rd_word = (s_axi_araddr == slc_pkg::REG_STRAP) ? 32'({done, strap}) :
                   (s_axi_araddr == slc_pkg::REG_OCTL)  ? 32'(octl) :
                   (s_axi_araddr == slc_pkg::REG_STAT)  ? 32'(cfg) :
                   (s_axi_araddr == slc_pkg::REG_GBUF)  ? 32'(gbuf) :
                   (s_axi_araddr == slc_pkg::REG_TSCAP) ? ts_cap : 32'h0000_0000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held   <= 1'h0;
      w_held    <= 1'h0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'h1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'h1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'h0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp  <= slc_pkg::RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'h1;
      s_axi_bresp  <= (wr_octl || wr_gbuf || wr_ro) ? slc_pkg::RESP_OK : slc_pkg::RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= slc_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'h1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? slc_pkg::RESP_OK : slc_pkg::RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'h0;
    end
  end

  // led polarity defaults follow the inverted straps at latch time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      octl <= slc_pkg::OCTL_RST;
    end else if (latch_now) begin
      octl.led_pol[slc_pkg::NLEDSTRAP-1:0] <= ~st3.led_pol;
    end else if (wr_octl) begin
      octl <= slc_pkg::slc_octl_s'(octl_wr[slc_pkg::OCTL_W-1:0]);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gbuf <= slc_pkg::GBUF_RST;
    end else if (wr_gbuf) begin
      gbuf <= slc_pkg::slc_gbuf_s'(gbuf_wr[slc_pkg::GBUF_W-1:0]);
    end
  end

  // ---------------------------------------------------------------------
  // pin drivers: push-pull, or open drain/source chosen by polarity
  // ---------------------------------------------------------------------
  logic [slc_pkg::NPIN-1:0] act;
  logic [slc_pkg::NPIN-1:0] pol;
  logic [slc_pkg::NPIN-1:0] od;
  logic [slc_pkg::NPIN-1:0] next_o;
  logic [slc_pkg::NPIN-1:0] next_oe;
  logic [slc_pkg::NPIN-1:0] pin_o;
  logic [slc_pkg::NPIN-1:0] pin_oe;
  logic                     int_pol;

  // open-drain interrupt cannot be active high
  assign int_pol = octl.int_od ? 1'h0 : octl.int_pol_inv;
  assign act = {ltc_evt_b, ltc_evt_a, sof_tx_evt, sof_rx_evt, wol_event, int_active, led_active};
  assign pol = {octl.ltc_pol_b, octl.ltc_pol_a, 1'h1, 1'h1, octl.wake_pol, int_pol,
                octl.led_pol};
  assign od  = {gbuf.ltc_b_od, gbuf.ltc_a_od, gbuf.sof_tx_od, gbuf.sof_rx_od, gbuf.wake_od,
                octl.int_od, octl.led_od};

  for (genvar i = 0; i < slc_pkg::NPIN; i++) begin : g_pin
    assign next_o[i]  = od[i] ? pol[i] : ~(act[i] ^ pol[i]);
    assign next_oe[i] = od[i] ? act[i] : 1'h1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_o   <= '0;
      pin_oe  <= '0;
      mdio_o  <= 1'h0;
      mdio_oe <= 1'h0;
    end else begin
      pin_o   <= next_o;
      pin_oe  <= next_oe;
      mdio_o  <= octl.mdio_od ? 1'h0 : mdio_out_data;
      mdio_oe <= mdio_out_en && !(octl.mdio_od && mdio_out_data);
    end
  end

  assign led_o             = pin_o[slc_pkg::NLED-1:0];
  assign led_oe            = pin_oe[slc_pkg::NLED-1:0];
  assign int_o             = pin_o[slc_pkg::PIN_INT];
  assign int_oe            = pin_oe[slc_pkg::PIN_INT];
  assign wake_event_out_o  = pin_o[slc_pkg::PIN_WAKE];
  assign wake_event_out_oe = pin_oe[slc_pkg::PIN_WAKE];
  assign sof_rx_o          = pin_o[slc_pkg::PIN_SOFRX];
  assign sof_rx_oe         = pin_oe[slc_pkg::PIN_SOFRX];
  assign sof_tx_o          = pin_o[slc_pkg::PIN_SOFTX];
  assign sof_tx_oe         = pin_oe[slc_pkg::PIN_SOFTX];
  assign ltc_a_o           = pin_o[slc_pkg::PIN_LTCA];
  assign ltc_a_oe          = pin_oe[slc_pkg::PIN_LTCA];
  assign ltc_b_o           = pin_o[slc_pkg::PIN_LTCB];
  assign ltc_b_oe          = pin_oe[slc_pkg::PIN_LTCB];

  // clock pin is a clock mux, not registered data
  assign ref_clk_pin_o  = gbuf.refclk_rx ? rx_ref_clk : local_ref_clk;
  assign ref_clk_pin_oe = strap.ref_clk_out && !gbuf.refclk_in;
  assign ts_ref_clk     = gbuf.refclk_in ? ref_clk_pin_i : local_ref_clk;

  // ---------------------------------------------------------------------
  // timestamp capture input
  // ---------------------------------------------------------------------
  logic g1;
  logic g2;
  logic g3;
  logic g_lvl;
  logic g_rise;

  assign g_rise = (g2 == g3) && g3 && !g_lvl;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      g1          <= 1'h0;
      g2          <= 1'h0;
      g3          <= 1'h0;
      g_lvl       <= 1'h0;
      ts_cap      <= '0;
      ltc_irq_clr <= 1'h0;
    end else begin
      g1          <= gpio_ts_in;
      g2          <= g1;
      g3          <= g2;
      ltc_irq_clr <= g_rise;
      if (g2 == g3) begin
        g_lvl <= g3;
      end
      if (g_rise) begin
        ts_cap <= ts_count;
      end
    end
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_latch_ready;
    !done && (fill == slc_pkg::SYNC_FILL) && (st2 == st3);
  endsequence
  sequence s_gpio_rise;
    (g2 == g3) && g3 && !g_lvl;
  endsequence

  property p_latch;
    s_latch_ready |=> done && (strap == $past(st3));
  endproperty
  a_latch: assert property (p_latch) else $error("straps not latched");
  property p_hold;
    done |=> $stable(strap) && done;
  endproperty
  a_hold: assert property (p_hold) else $error("latched straps changed");
  property p_led_polarity_strap;
    s_latch_ready |=> octl.led_pol[slc_pkg::NLEDSTRAP-1:0] == ~strap.led_pol;
  endproperty
  a_led_polarity_strap: assert property (p_led_polarity_strap) else $error("led polarity default wrong");
  property p_bcast;
    done && !strap.bcast && (req_addr == '0) |-> addr_hit;
  endproperty
  a_bcast: assert property (p_bcast) else $error("address zero not answered");
  property p_func;
    done && (strap.func == slc_pkg::FUNC_SWPD) |-> cfg.swpd_pll_on && !cfg.swpd_pll_off;
  endproperty
  a_func: assert property (p_func) else $error("function code decode wrong");
  property p_int_od;
    octl.int_od |=> !int_o;
  endproperty
  a_int_od: assert property (p_int_od) else $error("open-drain interrupt not low");
  property p_led;
    !octl.led_od[0] && led_active[0] |=> led_oe[0] && (led_o[0] == $past(octl.led_pol[0]));
  endproperty
  a_led: assert property (p_led) else $error("led level does not follow polarity");
  property p_mdio;
    octl.mdio_od |=> !mdio_o;
  endproperty
  a_mdio: assert property (p_mdio) else $error("open-drain data pin drives high");
  property p_sof;
    sof_rx_evt |=> sof_rx_o && sof_rx_oe;
  endproperty
  a_sof: assert property (p_sof) else $error("frame start pulse not active high");
  property p_cap;
    s_gpio_rise |=> ltc_irq_clr && (ts_cap == $past(ts_count)) ##1 !ltc_irq_clr;
  endproperty
  a_cap: assert property (p_cap) else $error("timestamp capture missed");
  property p_refclk;
    done && !strap.ref_clk_out |-> !ref_clk_pin_oe;
  endproperty
  a_refclk: assert property (p_refclk) else $error("clock pin driven while disabled");

endmodule : slc_strap_latch_pin_ctrl

//--- sim/slc_board_model.sv
// slc_board_model: strap resistors on the shared pins and the host that
// addresses management frames to the block
// assumes the bench sets the resistor pattern and when the pins turn into outputs
`timescale 1ns/1ps
module slc_board_model (
  input  wire logic                clk,
  input  wire slc_pkg::slc_strap_s pull,
  input  wire logic                busy,
  input  wire logic [4:0]          mgmt_addr,
  output slc_pkg::slc_strap_s      strap_pins,
  output logic [4:0]               req_addr
);
  // --------------------------------------------------------------
  // pin levels
  // --------------------------------------------------------------
  logic [17:0] wig = 18'h2aaaa;
  // resistors set the level; while busy every strap pin wiggles each cycle
  always_ff @(posedge clk) wig <= ~wig;
  assign strap_pins = busy ? (pull ^ wig) : pull;
  assign req_addr   = mgmt_addr;
endmodule : slc_board_model

//--- sim/slc_strap_latch_pin_ctrl_bench.sv
// slc_strap_latch_pin_ctrl_bench: self-checking bench of the strap latch
// assumes the package, the design and the board model are compiled first
`timescale 1ns/1ps
module slc_strap_latch_pin_ctrl_bench;
  localparam slc_pkg::slc_strap_s SA = '{5'h15, 3'h5, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 5'h1f};
  logic clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, addr_hit;
  logic int_active, wol_event, sof_rx_evt, sof_tx_evt, ltc_evt_a, ltc_evt_b, int_o, int_oe;
  logic wake_event_out_o, wake_event_out_oe, sof_rx_o, sof_rx_oe, sof_tx_o, sof_tx_oe;
  logic ltc_a_o, ltc_a_oe, ltc_b_o, ltc_b_oe, mdio_out_data, mdio_out_en, mdio_o, mdio_oe;
  logic local_ref_clk, rx_ref_clk, ref_clk_pin_i, ref_clk_pin_o, ref_clk_pin_oe, ts_ref_clk;
  logic gpio_ts_in, ltc_irq_clr, busy;
  logic [4:0]  s_axi_awaddr, s_axi_araddr, req_addr, mgmt_addr, led_active, led_o, led_oe;
  logic [31:0] s_axi_wdata, s_axi_rdata, ts_count;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  slc_pkg::slc_strap_s strap_pins, pull;
  slc_pkg::slc_stat_s  cfg;
  int failures, n_checks;

  slc_strap_latch_pin_ctrl dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .strap_pins, .cfg, .req_addr, .addr_hit, .led_active,
    .int_active, .wol_event, .sof_rx_evt, .sof_tx_evt, .ltc_evt_a, .ltc_evt_b, .led_o, .led_oe,
    .int_o, .int_oe, .wake_event_out_o, .wake_event_out_oe, .sof_rx_o, .sof_rx_oe, .sof_tx_o,
    .sof_tx_oe, .ltc_a_o, .ltc_a_oe, .ltc_b_o, .ltc_b_oe, .mdio_out_data, .mdio_out_en, .mdio_o,
    .mdio_oe, .local_ref_clk, .rx_ref_clk, .ref_clk_pin_i, .ref_clk_pin_o, .ref_clk_pin_oe,
    .ts_ref_clk, .gpio_ts_in, .ts_count, .ltc_irq_clr);
  slc_board_model board (.clk, .pull, .busy, .mgmt_addr, .strap_pins, .req_addr);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
  endtask : rdc

  task automatic rst(input slc_pkg::slc_strap_s s);
    pull   <= s;
    busy   <= 1'h0;
    arst_n <= 1'h0;
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    for (int n = 0; n < 12 && cfg.done !== 1'h1; n++) @(posedge clk);
    chk(cfg.done, 1'h1);
  endtask : rst

  // pin pair {o, oe} for push-pull or open type
  function automatic logic [1:0] ex(input logic act, input logic pol, input logic od);
    return od ? {pol, act} : {act ? pol : ~pol, 1'h1};
  endfunction : ex

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_strap(input slc_pkg::slc_strap_s s);
    logic [4:0]         a[3];
    slc_pkg::slc_stat_s st;
    rst(s);
    a = '{s.addr, 5'h00, s.addr ^ 5'h01};
    chk({cfg.addr, cfg.func}, {s.addr, s.func});
    chk({cfg.bcast_en, cfg.jack_dflt}, {!s.bcast, s.jack});
    chk({cfg.rgmii, cfg.refclk_en, cfg.tri_color},
        {s.iface_sel, s.ref_clk_out, !s.led_style});
    rdc(slc_pkg::REG_STRAP, {14'h0001, s}, slc_pkg::RESP_OK);
    rdc(slc_pkg::REG_OCTL, {16'h0000, 13'h0c80, ~s.led_pol}, slc_pkg::RESP_OK);
    foreach (a[i]) begin
      mgmt_addr <= a[i];
      repeat (2) @(posedge clk);
      chk(addr_hit, a[i] == s.addr || (!s.bcast && a[i] == 5'h00));
    end
    st = cfg;
    busy <= 1'h1;
    repeat (7) @(posedge clk);
    chk(cfg, st);
    busy <= 1'h0;
    $display("strap test done");
  endtask : t_strap

  task automatic t_func;
    slc_pkg::slc_strap_s s;
    logic [4:0]          c[4];
    s = SA;
    c = '{5'h07, 5'h08, 5'h09, 5'h0a};
    foreach (c[i]) begin
      s.func = c[i];
      rst(s);
      chk({cfg.swpd_pll_on, cfg.swpd_pll_off, cfg.dev_pd},
          {c[i] == 5'h08, c[i] == 5'h09, c[i] == 5'h07});
    end
    $display("function code test done");
  endtask : t_func

  task automatic t_out(input logic [15:0] oc, input logic [6:0] gb);
    logic [1:0] r;
    logic       act;
    wr(slc_pkg::REG_OCTL, {16'h0000, oc}, r);
    chk(r, slc_pkg::RESP_OK);
    wr(slc_pkg::REG_GBUF, {25'h0, gb}, r);
    chk(r, slc_pkg::RESP_OK);
    for (int k = 0; k < 2; k++) begin
      act = k[0];
      led_active <= {5{act}};
      {int_active, wol_event, sof_rx_evt, sof_tx_evt, ltc_evt_a, ltc_evt_b} <= {6{act}};
      mdio_out_data <= act;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 5; i++) chk({led_o[i], led_oe[i]}, ex(act, oc[i], oc[5 + i]));
      chk({int_o, int_oe}, ex(act, oc[11] & ~oc[10], oc[10]));
      chk({wake_event_out_o, wake_event_out_oe}, ex(act, oc[12], gb[0]));
      chk({sof_rx_o, sof_rx_oe, sof_tx_o, sof_tx_oe},
          {ex(act, 1'h1, gb[1]), ex(act, 1'h1, gb[2])});
      chk({ltc_a_o, ltc_a_oe, ltc_b_o, ltc_b_oe},
          {ex(act, oc[13], gb[3]), ex(act, oc[14], gb[4])});
      chk({mdio_o, mdio_oe}, oc[15] ? {1'h0, ~act} : {act, 1'h1});
    end
    mdio_out_en <= 1'h0;
    repeat (2) @(posedge clk);
    chk(mdio_oe, 1'h0);
    mdio_out_en <= 1'h1;
    $display("output control test done");
  endtask : t_out

  task automatic t_cap;
    int         hi;
    logic [1:0] r;
    hi = 0;
    ts_count   <= 32'h89ab_cdef;
    gpio_ts_in <= 1'h1;
    repeat (10) begin
      @(posedge clk);
      hi += ltc_irq_clr;
    end
    chk(hi, 32'h1);
    gpio_ts_in <= 1'h0;
    ts_count   <= 32'h0000_0000;
    wr(slc_pkg::REG_TSCAP, 32'h0000_0000, r);
    chk(r, slc_pkg::RESP_OK);
    rdc(slc_pkg::REG_TSCAP, 32'h89ab_cdef, slc_pkg::RESP_OK);
    wr(5'h14, 32'hffff_ffff, r);
    chk(r, slc_pkg::RESP_ERR);
    rdc(5'h14, 32'h0000_0000, slc_pkg::RESP_ERR);
    $display("capture test done");
  endtask : t_cap

  task automatic t_clk;
    logic [1:0] r;
    local_ref_clk <= 1'h1;
    rx_ref_clk    <= 1'h0;
    ref_clk_pin_i <= 1'h1;
    wr(slc_pkg::REG_GBUF, 32'h0000_0000, r);
    chk({ref_clk_pin_o, ref_clk_pin_oe}, {1'h1, pull.ref_clk_out});
    wr(slc_pkg::REG_GBUF, 32'h0000_0020, r);
    chk(ref_clk_pin_o, 1'h0);
    wr(slc_pkg::REG_GBUF, 32'h0000_0040, r);
    chk({ref_clk_pin_oe, ts_ref_clk}, 2'h1);
    $display("clock pin test done");
  endtask : t_clk

  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  initial begin
    #500000;
    failures++;
    close_out();
  end

  initial begin
    {arst_n, busy, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, int_active, wol_event, sof_rx_evt, sof_tx_evt, ltc_evt_a} = '0;
    {ltc_evt_b, mdio_out_data, local_ref_clk, rx_ref_clk, ref_clk_pin_i, gpio_ts_in} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, led_active, ts_count, mgmt_addr} = '0;
    s_axi_wstrb = 4'hf;
    mdio_out_en = 1'h1;
    t_strap(~SA);
    t_strap(SA);
    t_func();
    t_out(16'h181f, 7'h00);
    t_out(16'hcfea, 7'h1f);
    t_cap();
    t_clk();
    close_out();
  end
endmodule : slc_strap_latch_pin_ctrl_bench
